// ==== bench/dor_i2c_master.sv ====
// Serial bus master model for the register block
`timescale 1ns/10ps
module dor_i2c_master (
    input  wire logic core_clk, // Clock
    input  wire logic sda_w,    // Resolved data wire
    output logic      scl,      // Serial clock drive
    output logic      sda       // Data drive, 1 releases
);
    initial begin
        scl = 1'b1;
        sda = 1'b1;
    end
    task automatic clk_bit(input logic b);
        scl <= 1'b0;
        repeat (4) @(posedge core_clk);
        sda <= b;
        repeat (4) @(posedge core_clk);
        scl <= 1'b1;
        repeat (8) @(posedge core_clk);
    endtask
    task automatic start();
        clk_bit(1'b1);
        sda <= 1'b0;
        repeat (8) @(posedge core_clk);
    endtask
    task automatic stop();
        clk_bit(1'b0);
        sda <= 1'b1;
        repeat (8) @(posedge core_clk);
    endtask
    task automatic xfer(input logic [7:0] w, input logic nak, output logic [7:0] r,
                        output logic ack);
        for (int i = 7; i >= 0; i--) begin
            clk_bit(w[i]);
            r[i] = sda_w;
        end
        clk_bit(nak);
        ack = !sda_w;
    endtask
endmodule

// ==== bench/dor_regs_chk.sv ====
// Port checker for the converter register block
`timescale 1ns/10ps
module dor_regs_chk #(
    parameter int RES_BITS = 12 // Code resolution
) (
    input wire logic             core_clk,   // Clock
    input wire logic             srst,       // Reset
    input wire logic             scl_in,     // Serial clock
    input wire logic             sda_in,     // Data wire
    input wire logic             sda_oe_n,   // Data drive enable
    input wire logic             por_status, // Power-on flag
    input dor_pkg::dor_chan_ctl_t ch_ctl [dor_pkg::NUM_CH] // Channel controls
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    sequence s_start;
        scl_in && $fell(sda_in);
    endsequence
    a_por_set: assert property ($fell(srst) |-> por_status)
        else $error("power-on flag low after reset");
    a_por_hold: assert property (!por_status |=> !por_status)
        else $error("power-on flag set without reset");
    a_start_idle: assert property (s_start |-> sda_oe_n [*8])
        else $error("data driven right after start");
    a_drive_scl_low: assert property ($fell(sda_oe_n) |-> !scl_in)
        else $error("data drive began with clock high");
    for (genvar c = 0; c < 2; c++) begin : g_ch
        a_code_width: assert property ((ch_ctl[c].code >> RES_BITS) == '0)
            else $error("code bits above resolution set");
        a_buf_match: assert property (ch_ctl[c].ref_buf_en == ch_ctl[c].ref_sel[0])
            else $error("reference buffer mismatch");
        a_bg_on: assert property (ch_ctl[c].ref_sel == dor_pkg::REF_BANDGAP
            |-> ch_ctl[c].bandgap_en)
            else $error("band gap off while selected");
        a_bg_off: assert property (!ch_ctl[c].ref_sel[0] |-> !ch_ctl[c].bandgap_en)
            else $error("band gap on with supply or pin");
        a_pd_flag: assert property (ch_ctl[c].powered_down
            == (ch_ctl[c].pd_mode != dor_pkg::PD_NORMAL))
            else $error("power-down flag mismatch");
    end
endmodule
bind dor_regs dor_regs_chk #(.RES_BITS(RES_BITS)) dor_regs_chk_i (.core_clk, .srst,
    .scl_in, .sda_in, .sda_oe_n, .por_status, .ch_ctl);

// ==== bench/dor_regs_tb.sv ====
// Self-checking bench for the converter register block
`timescale 1ns/10ps
module dor_regs_tb;
    logic                   core_clk;
    logic                   srst;
    logic                   cold_rst;
    logic [1:0]             addr_pins;
    logic                   sda_out;
    logic                   sda_oe_n;
    logic                   por_status;
    logic                   scl;
    logic                   m_sda;
    logic [7:0]             sa;
    int                     mismatches;
    int                     cmp_count;
    dor_pkg::dor_chan_ctl_t ch_ctl [dor_pkg::NUM_CH];
    wire                    sda_w = sda_oe_n ? m_sda : sda_out;
    dor_regs dor_regs_i (.core_clk(core_clk), .srst(srst), .cold_rst(cold_rst), .scl_in(scl),
        .sda_in(sda_w), .address_select_pin_hi(addr_pins[1]),
        .address_select_pin_lo(addr_pins[0]), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
        .por_status(por_status), .ch_ctl(ch_ctl));
    dor_i2c_master dor_i2c_master_i (.core_clk(core_clk), .sda_w(sda_w), .scl(scl), .sda(m_sda));
    initial begin
        core_clk = 1'b0;
        forever #5 core_clk = ~core_clk;
    end
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    task automatic chk_w(input logic [15:0] e, input logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("wrong value at %0t: expected %h got %h", $time, e, g);
        end
    endtask
    task automatic chk_b(input logic e, input logic g);
        chk_w({15'h0, e}, {15'h0, g});
    endtask
    task automatic rst(input logic c);
        cold_rst <= c;
        srst <= 1'b1;
        repeat (2) @(posedge core_clk);
        cold_rst <= 1'b0;
        @(posedge core_clk);
        srst <= 1'b0;
        repeat (4) @(posedge core_clk);
    endtask
    task automatic wr(input logic [4:0] a, input logic [15:0] d, output logic ok);
        logic [7:0] r;
        logic k0, k1, k2, k3;
        dor_i2c_master_i.start();
        dor_i2c_master_i.xfer(sa, 1'b1, r, k0);
        dor_i2c_master_i.xfer({a, 3'b000}, 1'b1, r, k1);
        dor_i2c_master_i.xfer(d[15:8], 1'b1, r, k2);
        dor_i2c_master_i.xfer(d[7:0], 1'b1, r, k3);
        dor_i2c_master_i.stop();
        ok = k0 & k1 & k2 & k3;
    endtask
    task automatic rd(input logic [4:0] a, output logic [15:0] d, output logic ok);
        logic [7:0] r, h;
        logic k0, k1, k2, k3;
        dor_i2c_master_i.start();
        dor_i2c_master_i.xfer(sa, 1'b1, r, k0);
        dor_i2c_master_i.xfer({a, 3'b110}, 1'b1, r, k1);
        dor_i2c_master_i.start();
        dor_i2c_master_i.xfer(sa | 8'h01, 1'b1, r, k2);
        dor_i2c_master_i.xfer(8'hff, 1'b0, h, k3);
        dor_i2c_master_i.xfer(8'hff, 1'b1, r, k3);
        dor_i2c_master_i.stop();
        d = {h, r};
        ok = k0 & k1 & k2;
    endtask
    task automatic t_por();
        logic [15:0] d;
        logic ok;
        chk_b(1'b1, por_status);
        rd(dor_pkg::ADDR_STATUS, d, ok);
        chk_w(16'h0080, d);
        chk_b(1'b0, por_status);
        rd(dor_pkg::ADDR_STATUS, d, ok);
        chk_w(16'h0000, d);
        chk_w(16'h07ff, {4'h0, ch_ctl[0].code});
        $display("t_por done");
    endtask
    task automatic t_code();
        logic [15:0] d;
        logic ok;
        wr(dor_pkg::ADDR_CODE0_V, 16'hffff, ok);
        rd(dor_pkg::ADDR_CODE0_V, d, ok);
        chk_w(16'h0fff, d);
        chk_w(16'h0fff, {4'h0, ch_ctl[0].code});
        wr(dor_pkg::ADDR_CODE1_V, 16'h0000, ok);
        chk_w(16'h0000, {4'h0, ch_ctl[1].code});
        wr(dor_pkg::ADDR_CODE1_NV, 16'hf123, ok);
        rst(1'b0);
        chk_b(1'b1, por_status);
        rd(dor_pkg::ADDR_CODE1_V, d, ok);
        chk_w(16'h0123, d);
        chk_w(16'h07ff, {4'h0, ch_ctl[0].code});
        $display("t_code done");
    endtask
    task automatic t_fields();
        logic [15:0] d;
        logic [1:0] c;
        logic ok;
        for (int i = 0; i < 4; i++) begin
            c = {i[0], ~i[1]};
            wr(dor_pkg::ADDR_VREF_V, {12'hfff, ~c, c}, ok);
            rd(dor_pkg::ADDR_VREF_V, d, ok);
            chk_w({12'h000, ~c, c}, d);
            chk_w({14'h0, c}, {14'h0, ch_ctl[0].ref_sel});
            chk_b(c[0], ch_ctl[0].ref_buf_en);
            chk_b(~i[1], ch_ctl[0].bandgap_en);
            chk_w({14'h0, ~c}, {14'h0, ch_ctl[1].ref_sel});
            wr(dor_pkg::ADDR_PD_V, {12'hfff, ~c, c}, ok);
            rd(dor_pkg::ADDR_PD_V, d, ok);
            chk_w({12'h000, ~c, c}, d);
            chk_w({14'h0, c}, {14'h0, ch_ctl[0].pd_mode});
            chk_b(c != 2'b00, ch_ctl[0].powered_down);
        end
        wr(dor_pkg::ADDR_PD_V, 16'h000f, ok);
        wr(dor_pkg::ADDR_VREF_V, 16'h0000, ok);
        chk_b(1'b1, ch_ctl[1].powered_down);
        chk_b(1'b0, ch_ctl[1].bandgap_en);
        wr(dor_pkg::ADDR_PD_V, 16'h0000, ok);
        wr(dor_pkg::ADDR_VREF_V, 16'h0006, ok);
        chk_b(1'b1, ch_ctl[1].bandgap_en);
        chk_b(1'b0, ch_ctl[1].powered_down);
        $display("t_fields done");
    endtask
    task automatic t_err();
        logic [15:0] d;
        logic ok;
        rd(5'h02, d, ok);
        chk_b(1'b0, ok);
        chk_w(16'hffff, d);
        rd(dor_pkg::ADDR_VREF_V, d, ok);
        chk_b(1'b1, ok);
        chk_w(16'h0006, d);
        wr(5'h0b, 16'h1234, ok);
        chk_b(1'b0, ok);
        wr(dor_pkg::ADDR_VREF_NV, 16'h0009, ok);
        rd(dor_pkg::ADDR_VREF_NV, d, ok);
        chk_w(16'h0009, d);
        $display("t_err done");
    endtask
    task automatic t_addr();
        logic [15:0] d;
        logic ok;
        addr_pins <= 2'b01;
        repeat (4) @(posedge core_clk);
        rd(dor_pkg::ADDR_VREF_V, d, ok);
        chk_b(1'b0, ok);
        sa = 8'hc2;
        rd(dor_pkg::ADDR_VREF_V, d, ok);
        chk_b(1'b1, ok);
        chk_w(16'h0006, d);
        $display("t_addr done");
    endtask
    initial begin
        #1ms;
        mismatches++;
        conclude();
    end
    initial begin
        srst = 1'b1;
        cold_rst = 1'b1;
        addr_pins = 2'b00;
        sa = 8'hc0;
        mismatches = 0;
        cmp_count = 0;
        @(posedge core_clk);
        rst(1'b1);
        t_por();
        t_code();
        t_fields();
        t_err();
        t_addr();
        conclude();
    end
endmodule

// ==== core/dor_i2c_front.sv ====
// Serial line synchroniser and bus event detector
`timescale 1ns/10ps
module dor_i2c_front (
    input  wire logic          core_clk, // System clock
    input  wire logic          srst,     // Synchronous reset
    input  wire logic          scl_in,   // Serial clock pin
    input  wire logic          sda_in,   // Serial data pin level
    output dor_pkg::dor_bus_evt_t evt    // Registered bus events
);
    logic scl_q1;
    logic scl_q2;
    logic scl_q3;
    logic sda_q1;
    logic sda_q2;
    logic sda_q3;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            scl_q1 <= 1'b1;
            scl_q2 <= 1'b1;
            scl_q3 <= 1'b1;
            sda_q1 <= 1'b1;
            sda_q2 <= 1'b1;
            sda_q3 <= 1'b1;
        end else begin
            scl_q1 <= scl_in;
            scl_q2 <= scl_q1;
            scl_q3 <= scl_q2;
            sda_q1 <= sda_in;
            sda_q2 <= sda_q1;
            sda_q3 <= sda_q2;
        end
    end

    // Start and stop are data edges while the clock stays high
    always_ff @(posedge core_clk) begin
        if (srst) begin
            evt <= '{scl_rise: 1'b0, scl_fall: 1'b0, start: 1'b0, stop: 1'b0, sda: 1'b1};
        end else begin
            evt.scl_rise <= scl_q2 & ~scl_q3;
            evt.scl_fall <= ~scl_q2 & scl_q3;
            evt.start    <= scl_q2 & scl_q3 & sda_q3 & ~sda_q2;
            evt.stop     <= scl_q2 & scl_q3 & ~sda_q3 & sda_q2;
            evt.sda      <= sda_q2;
        end
    end
endmodule

// ==== core/dor_regs.sv ====
// Serial slave and output code, reference and power-down registers
`timescale 1ns/10ps
module dor_regs #(
    parameter int RES_BITS  = 12, // Code resolution: 8, 10 or 12
    parameter int DUAL      = 1,  // 1 for two channels
    parameter int NV_PART   = 1,  // 1 when stored copies exist
    parameter int ADDR_PINS = 1   // 1 when select pins set address bits
) (
    input  wire logic           core_clk,        // System clock
    input  wire logic           srst,            // Power-on or brown-out reset
    input  wire logic           cold_rst,        // Loads stored copies with defaults
    input  wire logic           scl_in,          // Serial clock pin
    input  wire logic           sda_in,          // Serial data pin level
    input  wire logic           address_select_pin_hi, // Address bit 1 pin
    input  wire logic           address_select_pin_lo, // Address bit 0 pin
    output logic                sda_out,         // Data drive level, always low
    output logic                sda_oe_n,        // Low while pulling data low
    output logic                por_status,      // Power-on status flag
    output dor_pkg::dor_chan_ctl_t ch_ctl [dor_pkg::NUM_CH] // Per-channel control
);
    localparam logic [11:0] CODE_MASK  = 12'((32'd1 << RES_BITS) - 32'd1);
    localparam logic [11:0] CODE_MID   = CODE_MASK >> 1;
    localparam logic [3:0]  FIELD_MASK = (DUAL != 0) ? dor_pkg::FIELD_MASK_DUAL
                                                     : dor_pkg::FIELD_MASK_SINGLE;

    dor_pkg::dor_bus_evt_t evt;
    dor_pkg::dor_state_t   state;
    dor_pkg::dor_kind_t    kind;
    dor_pkg::dor_kind_t    next_kind;

    logic [1:0]  apin_meta;
    logic [1:0]  apin_sync;
    logic [6:0]  slave_addr;
    logic [3:0]  bit_cnt;
    logic [7:0]  rx_sh;
    logic [7:0]  tx_sh;
    logic [7:0]  rd_lo;
    logic [7:0]  data_hi;
    logic [4:0]  reg_addr;
    logic [4:0]  cmd_addr;
    logic [1:0]  cmd_op;
    logic        accept;
    logic        want_tx;
    logic        go_tx;
    logic        tx_lo;
    logic        mack_ok;
    logic        rd_err;
    logic [15:0] rd_word;
    logic        wr_stb;
    logic [4:0]  wr_at;
    logic [15:0] wr_word;
    logic        por_clr;
    logic [11:0] code_v  [dor_pkg::NUM_CH];
    logic [11:0] code_nv [dor_pkg::NUM_CH];
    logic [3:0]  vref_v;
    logic [3:0]  vref_nv;
    logic [3:0]  pd_v;
    logic [3:0]  pd_nv;

    dor_i2c_front u_front (
        .core_clk (core_clk),
        .srst     (srst),
        .scl_in   (scl_in),
        .sda_in   (sda_in),
        .evt      (evt)
    );

    always_ff @(posedge core_clk) begin
        if (srst) begin
            apin_meta <= 2'h0;
            apin_sync <= 2'h0;
        end else begin
            apin_meta <= {address_select_pin_hi, address_select_pin_lo};
            apin_sync <= apin_meta;
        end
    end

    assign slave_addr = (ADDR_PINS != 0)
        ? {dor_pkg::SLAVE_ADDR_DEFAULT[6:2], apin_sync}
        : dor_pkg::SLAVE_ADDR_DEFAULT;

    function automatic logic is_impl(input logic [4:0] a);
        logic ok;
        ok = (a == dor_pkg::ADDR_CODE0_V) || (a == dor_pkg::ADDR_VREF_V) ||
             (a == dor_pkg::ADDR_PD_V) || (a == dor_pkg::ADDR_STATUS) ||
             ((a == dor_pkg::ADDR_CODE1_V) && (DUAL != 0));
        if (NV_PART != 0) begin
            ok = ok || (a == dor_pkg::ADDR_CODE0_NV) || (a == dor_pkg::ADDR_VREF_NV) ||
                 (a == dor_pkg::ADDR_PD_NV) ||
                 ((a == dor_pkg::ADDR_CODE1_NV) && (DUAL != 0));
        end
        return ok;
    endfunction

    // Unimplemented bits come back as zero
    function automatic logic [15:0] read_word(input logic [4:0] a);
        logic [15:0] w;
        w = 16'h0000;
        if (a == dor_pkg::ADDR_CODE0_V) begin
            w[11:0] = code_v[0];
        end else if (a == dor_pkg::ADDR_CODE1_V) begin
            w[11:0] = code_v[1];
        end else if (a == dor_pkg::ADDR_CODE0_NV) begin
            w[11:0] = code_nv[0];
        end else if (a == dor_pkg::ADDR_CODE1_NV) begin
            w[11:0] = code_nv[1];
        end else if (a == dor_pkg::ADDR_VREF_V) begin
            w[3:0] = vref_v;
        end else if (a == dor_pkg::ADDR_VREF_NV) begin
            w[3:0] = vref_nv;
        end else if (a == dor_pkg::ADDR_PD_V) begin
            w[3:0] = pd_v;
        end else if (a == dor_pkg::ADDR_PD_NV) begin
            w[3:0] = pd_nv;
        end else if (a == dor_pkg::ADDR_STATUS) begin
            w[dor_pkg::POR_FLAG_BIT] = por_status;
        end
        return w;
    endfunction

    assign cmd_addr = rx_sh[dor_pkg::CMD_ADDR_LSB +: 5];
    assign cmd_op   = rx_sh[dor_pkg::CMD_OP_LSB +: 2];
    assign rd_word  = rd_err ? dor_pkg::WORD_ALL_ONES : read_word(reg_addr);

    // Acknowledge decision for the byte just received
    always_comb begin
        accept    = 1'b0;
        want_tx   = 1'b0;
        next_kind = kind;
        case (kind)
            dor_pkg::K_ADDR: begin
                accept    = (rx_sh[7:1] == slave_addr);
                want_tx   = rx_sh[0];
                next_kind = dor_pkg::K_CMD;
            end
            dor_pkg::K_CMD: begin
                accept    = is_impl(cmd_addr) &&
                            ((cmd_op == dor_pkg::OP_WRITE) || (cmd_op == dor_pkg::OP_READ));
                next_kind = dor_pkg::K_DHI;
            end
            dor_pkg::K_DHI: begin
                accept    = 1'b1;
                next_kind = dor_pkg::K_DLO;
            end
            default: begin
                accept    = 1'b1;
                next_kind = dor_pkg::K_CMD;
            end
        endcase
    end

    // Byte engine: open-drain data, released means one
    always_ff @(posedge core_clk) begin
        wr_stb  <= 1'b0;
        por_clr <= 1'b0;
        if (srst) begin
            state    <= dor_pkg::ST_IDLE;
            kind     <= dor_pkg::K_ADDR;
            bit_cnt  <= 4'h0;
            rx_sh    <= 8'h00;
            tx_sh    <= 8'hff;
            rd_lo    <= 8'h00;
            data_hi  <= 8'h00;
            reg_addr <= 5'h00;
            go_tx    <= 1'b0;
            tx_lo    <= 1'b0;
            mack_ok  <= 1'b0;
            rd_err   <= 1'b0;
            wr_at    <= 5'h00;
            wr_word  <= 16'h0000;
            sda_oe_n <= 1'b1;
        end else if (evt.start) begin
            state    <= dor_pkg::ST_RX;
            kind     <= dor_pkg::K_ADDR;
            bit_cnt  <= 4'h0;
            sda_oe_n <= 1'b1;
        end else if (evt.stop) begin
            state    <= dor_pkg::ST_IDLE;
            rd_err   <= 1'b0;
            sda_oe_n <= 1'b1;
        end else begin
            case (state)
                dor_pkg::ST_RX: begin
                    if (evt.scl_rise) begin
                        rx_sh   <= {rx_sh[6:0], evt.sda};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (evt.scl_fall && bit_cnt == dor_pkg::BIT_CNT_LAST) begin
                        bit_cnt <= 4'h0;
                        kind    <= next_kind;
                        go_tx   <= accept && want_tx;
                        if (accept) begin
                            sda_oe_n <= 1'b0;
                            state    <= dor_pkg::ST_ACK;
                        end else begin
                            state <= dor_pkg::ST_ERR;
                        end
                        if (kind == dor_pkg::K_CMD) begin
                            reg_addr <= cmd_addr;
                            rd_err   <= !accept && (cmd_op == dor_pkg::OP_READ);
                        end
                        if (kind == dor_pkg::K_DHI) begin
                            data_hi <= rx_sh;
                        end
                        if (kind == dor_pkg::K_DLO) begin
                            wr_stb  <= 1'b1;
                            wr_at   <= reg_addr;
                            wr_word <= {data_hi, rx_sh};
                        end
                    end
                end
                dor_pkg::ST_ACK: begin
                    if (evt.scl_fall) begin
                        if (go_tx) begin
                            tx_sh    <= rd_word[15:8];
                            sda_oe_n <= rd_word[15];
                            // Low byte frozen now, so the flag clear cannot alter it
                            rd_lo    <= rd_word[7:0];
                            tx_lo    <= 1'b1;
                            por_clr  <= !rd_err && (reg_addr == dor_pkg::ADDR_STATUS);
                            state    <= dor_pkg::ST_TX;
                        end else begin
                            sda_oe_n <= 1'b1;
                            state    <= dor_pkg::ST_RX;
                        end
                    end
                end
                dor_pkg::ST_TX: begin
                    if (evt.scl_rise) begin
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (evt.scl_fall) begin
                        if (bit_cnt == dor_pkg::BIT_CNT_LAST) begin
                            bit_cnt  <= 4'h0;
                            sda_oe_n <= 1'b1;
                            state    <= dor_pkg::ST_MACK;
                        end else begin
                            sda_oe_n <= tx_sh[6];
                            tx_sh    <= {tx_sh[6:0], 1'b1};
                        end
                    end
                end
                dor_pkg::ST_MACK: begin
                    if (evt.scl_rise) begin
                        mack_ok <= ~evt.sda;
                    end else if (evt.scl_fall) begin
                        if (mack_ok) begin
                            tx_sh    <= tx_lo ? rd_lo : rd_word[15:8];
                            sda_oe_n <= tx_lo ? rd_lo[7] : rd_word[15];
                            if (!tx_lo) begin
                                rd_lo <= rd_word[7:0];
                            end
                            tx_lo    <= ~tx_lo;
                            state    <= dor_pkg::ST_TX;
                        end else begin
                            state <= dor_pkg::ST_ERR;
                        end
                    end
                end
                default: begin
                    sda_oe_n <= 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        sda_out <= 1'b0;
    end

    // Only reset sets the flag, so no event can be lost to a clear
    always_ff @(posedge core_clk) begin
        if (srst) begin
            por_status <= 1'b1;
        end else if (por_clr) begin
            por_status <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (cold_rst) begin
            vref_nv <= dor_pkg::FIELD_RESET;
        end else if (wr_stb && wr_at == dor_pkg::ADDR_VREF_NV && NV_PART != 0) begin
            vref_nv <= wr_word[3:0] & FIELD_MASK;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            vref_v <= (NV_PART != 0) ? vref_nv : dor_pkg::FIELD_RESET;
        end else if (wr_stb && wr_at == dor_pkg::ADDR_VREF_V) begin
            vref_v <= wr_word[3:0] & FIELD_MASK;
        end
    end

    always_ff @(posedge core_clk) begin
        if (cold_rst) begin
            pd_nv <= dor_pkg::FIELD_RESET;
        end else if (wr_stb && wr_at == dor_pkg::ADDR_PD_NV && NV_PART != 0) begin
            pd_nv <= wr_word[3:0] & FIELD_MASK;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            pd_v <= (NV_PART != 0) ? pd_nv : dor_pkg::FIELD_RESET;
        end else if (wr_stb && wr_at == dor_pkg::ADDR_PD_V) begin
            pd_v <= wr_word[3:0] & FIELD_MASK;
        end
    end

    for (genvar ch = 0; ch < dor_pkg::NUM_CH; ch++) begin : g_ch
        localparam logic [4:0] A_V  = (ch == 0) ? dor_pkg::ADDR_CODE0_V : dor_pkg::ADDR_CODE1_V;
        localparam logic [4:0] A_NV = (ch == 0) ? dor_pkg::ADDR_CODE0_NV : dor_pkg::ADDR_CODE1_NV;
        dor_pkg::dor_ref_sel_t sel;
        dor_pkg::dor_pd_mode_t pdm;

        assign sel = dor_pkg::dor_ref_sel_t'(vref_v[2*ch +: 2]);
        assign pdm = dor_pkg::dor_pd_mode_t'(pd_v[2*ch +: 2]);

        always_ff @(posedge core_clk) begin
            if (cold_rst) begin
                code_nv[ch] <= CODE_MID;
            end else if (wr_stb && wr_at == A_NV && NV_PART != 0) begin
                code_nv[ch] <= wr_word[11:0] & CODE_MASK;
            end
        end

        always_ff @(posedge core_clk) begin
            if (srst) begin
                code_v[ch] <= (NV_PART != 0) ? code_nv[ch] : CODE_MID;
            end else if (wr_stb && wr_at == A_V) begin
                code_v[ch] <= wr_word[11:0] & CODE_MASK;
            end
        end

        always_ff @(posedge core_clk) begin
            if (srst) begin
                ch_ctl[ch] <= '{code: 12'h000, ref_sel: dor_pkg::REF_SUPPLY,
                                ref_buf_en: 1'b0, bandgap_en: 1'b0,
                                pd_mode: dor_pkg::PD_NORMAL, powered_down: 1'b0};
            end else begin
                ch_ctl[ch].code         <= code_v[ch];
                ch_ctl[ch].ref_sel      <= sel;
                ch_ctl[ch].ref_buf_en   <= (sel == dor_pkg::REF_PIN_BUF) ||
                                           (sel == dor_pkg::REF_BANDGAP);
                ch_ctl[ch].pd_mode      <= pdm;
                ch_ctl[ch].powered_down <= (pdm != dor_pkg::PD_NORMAL);
                if (sel == dor_pkg::REF_BANDGAP) begin
                    ch_ctl[ch].bandgap_en <= 1'b1;
                end else if (sel == dor_pkg::REF_SUPPLY || sel == dor_pkg::REF_PIN_UNBUF) begin
                    ch_ctl[ch].bandgap_en <= 1'b0;
                end
            end
        end
    end
endmodule

// ==== pkg/dor_pkg.sv ====
// Shared constants and types for the converter register block
package dor_pkg;

    localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h60;

    localparam logic [4:0] ADDR_CODE0_V  = 5'h00;
    localparam logic [4:0] ADDR_CODE1_V  = 5'h01;
    localparam logic [4:0] ADDR_VREF_V   = 5'h08;
    localparam logic [4:0] ADDR_PD_V     = 5'h09;
    localparam logic [4:0] ADDR_STATUS   = 5'h0a;
    localparam logic [4:0] ADDR_CODE0_NV = 5'h10;
    localparam logic [4:0] ADDR_CODE1_NV = 5'h11;
    localparam logic [4:0] ADDR_VREF_NV  = 5'h18;
    localparam logic [4:0] ADDR_PD_NV    = 5'h19;

    localparam logic [1:0] OP_WRITE = 2'h0;
    localparam logic [1:0] OP_READ  = 2'h3;
    localparam int CMD_ADDR_LSB = 3;
    localparam int CMD_OP_LSB   = 1;

    localparam int POR_FLAG_BIT = 7;
    localparam int CODE_W       = 12;
    localparam int FIELD_W      = 4;
    localparam int NUM_CH       = 2;

    localparam logic [3:0]  FIELD_MASK_SINGLE = 4'h3;
    localparam logic [3:0]  FIELD_MASK_DUAL   = 4'hf;
    localparam logic [3:0]  FIELD_RESET       = 4'h0;
    localparam logic [3:0]  BIT_CNT_LAST      = 4'h8;
    localparam logic [15:0] WORD_ALL_ONES     = 16'hffff;

    typedef enum logic [1:0] {REF_SUPPLY, REF_BANDGAP, REF_PIN_UNBUF, REF_PIN_BUF} dor_ref_sel_t;
    typedef enum logic [1:0] {PD_NORMAL, PD_LOAD_1K, PD_LOAD_100K, PD_OPEN} dor_pd_mode_t;
    typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACK, ST_TX, ST_MACK, ST_ERR} dor_state_t;
    typedef enum logic [1:0] {K_ADDR, K_CMD, K_DHI, K_DLO} dor_kind_t;

    typedef struct packed {
        logic [CODE_W-1:0] code;
        dor_ref_sel_t      ref_sel;
        logic              ref_buf_en;
        logic              bandgap_en;
        dor_pd_mode_t      pd_mode;
        logic              powered_down;
    } dor_chan_ctl_t;

    typedef struct packed {
        logic scl_rise;
        logic scl_fall;
        logic start;
        logic stop;
        logic sda;
    } dor_bus_evt_t;

endpackage
